// ---- verilog/pcglc_pkg.sv ----
/*
 * Constants for the pulse-count configuration decoder and gain sequencer:
 * pulse-count codes, wake-up defaults and timing figures with cycle counts.
 * Assumes a single 200 MHz reference clock.
 */
// Summary of operation
// RULE1 - After wake-up: gain control on, clip-avoid plus limit, 18 dB, 1% target.
// RULE2 - Count 01 disables gain control, count 02 enables it.
// RULE3 - Count 03 restores every setting to its wake-up default.
// RULE4 - Count 04 selects 12 dB gain, count 05 selects 18 dB.
// RULE5 - Counts 06 to 13 select distortion targets 1% up to 20%.
// RULE6 - Count 14 selects clip-avoid plus limit, 15 clip-avoid only.
// RULE7 - Counts 16 to 23 select peak limit 0.45 V to 3.6 V in 0.45 V steps.
// RULE8 - With limiting active the output is held under the peak limit.
// RULE9 - With gain control on, near-clipping steps the gain down.
// RULE10 - Output ceiling follows the monitored supply level continuously.
// RULE11 - Two gain decreases are at least one attack interval apart.
// RULE12 - A gain increase waits at least the hold interval after a decrease.
// RULE13 - Two gain increases are at least one release interval apart.
// RULE14 - Bridge current above 2 A floats both outputs until it clears.
// RULE15 - Host pulses no faster than 100 kHz.
// RULE16 - Line idle high 300 to 400 us after a burst applies the count.
// RULE17 - Line held low 300 to 400 us enters shutdown.
// RULE18 - After leaving shutdown the device is awake within 500 us.
// RULE19 - Low-going pulses are counted; setting applied after idle-high interval.
// RULE20 - A count of zero or above 23 changes nothing.

package pcglc_pkg;

	// ************************************************************
	// Pulse-count codes
	// ************************************************************
	localparam logic [4:0] CNT_AGC_OFF    = 5'h01;
	localparam logic [4:0] CNT_AGC_ON     = 5'h02;
	localparam logic [4:0] CNT_RESET      = 5'h03;
	localparam logic [4:0] CNT_GAIN_12    = 5'h04;
	localparam logic [4:0] CNT_GAIN_18    = 5'h05;
	localparam logic [4:0] CNT_THD_FIRST  = 5'h06;
	localparam logic [4:0] CNT_THD_LAST   = 5'h0d;
	localparam logic [4:0] CNT_CLIP_LIMIT = 5'h0e;
	localparam logic [4:0] CNT_CLIP_ONLY  = 5'h0f;
	localparam logic [4:0] CNT_PEAK_FIRST = 5'h10;
	localparam logic [4:0] CNT_PEAK_LAST  = 5'h17;
	localparam logic [4:0] CNT_SAT        = 5'h18;

	// ************************************************************
	// Wake-up defaults
	// ************************************************************
	localparam logic       RST_AGC_EN   = 1'h1;
	localparam logic       RST_LIMIT_EN = 1'h1;
	localparam logic       RST_GAIN_18  = 1'h1;
	localparam logic [2:0] RST_THD_SEL  = 3'h0;
	localparam logic [2:0] RST_PEAK_SEL = 3'h7;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ        = 200;
	localparam int MAX_PULSE_KHZ  = 100;
	localparam int VALID_US       = 300;
	localparam int SHUTDOWN_US    = 300;
	localparam int WAKE_US        = 500;
	localparam int ATTACK_US      = 10;
	localparam int HOLD_US        = 100;
	localparam int RELEASE_US     = 50;
	localparam int VALID_CYC      = VALID_US * CLK_MHZ;
	localparam int SHUTDOWN_CYC   = SHUTDOWN_US * CLK_MHZ;
	localparam int WAKE_CYC       = WAKE_US * CLK_MHZ;
	localparam int ATTACK_CYC     = ATTACK_US * CLK_MHZ;
	localparam int HOLD_CYC       = HOLD_US * CLK_MHZ;
	localparam int RELEASE_CYC    = RELEASE_US * CLK_MHZ;
	localparam int TMR_W          = 17;
	localparam logic [5:0] ATTEN_MAX = 6'h3f;

	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'h0,
		ST_WAKE     = 2'h1,
		ST_ACTIVE   = 2'h3
	} pcglc_state_e;

endpackage : pcglc_pkg

// ---- verilog/pcglc_top.sv ----
/*
 * One-wire pulse-count configuration decoder with the gain control
 * sequencer it configures and the bridge overcurrent release.
 * Assumes every input is synchronous to i_ref_clk; the analog side
 * supplies near-clip, over-limit, supply and overcurrent indications.
 */
`timescale 1ns/1ps

module pcglc_top
	import pcglc_pkg::*;
#(
	parameter int P_VALID_CYC    = VALID_CYC,
	parameter int P_SHUTDOWN_CYC = SHUTDOWN_CYC,
	parameter int P_WAKE_CYC     = WAKE_CYC,
	parameter int P_HOLD_CYC     = HOLD_CYC,
	parameter int P_RELEASE_CYC  = RELEASE_CYC
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_pulse_config_pin,
	input  wire logic       i_clip_near,
	input  wire logic       i_over_limit,
	input  wire logic [7:0] i_supply_level,
	input  wire logic       i_overcurrent,
	input  wire logic       i_pwm_p,
	input  wire logic       i_pwm_m,
	output logic            o_agc_en,
	output logic            o_limit_en,
	output logic            o_gain_18db,
	output logic [2:0]      o_thd_sel,
	output logic [2:0]      o_peak_sel,
	output logic [5:0]      o_gain_atten,
	output logic [7:0]      o_out_ceiling,
	output logic            o_bridge_p,
	output logic            o_bridge_p_oe,
	output logic            o_bridge_m,
	output logic            o_bridge_m_oe,
	output logic            o_shutdown,
	output logic            o_awake
);

	localparam logic [TMR_W-1:0] VALID_LIM   = P_VALID_CYC[TMR_W-1:0];
	localparam logic [TMR_W-1:0] SHDN_LIM    = P_SHUTDOWN_CYC[TMR_W-1:0];
	localparam logic [TMR_W-1:0] WAKE_LIM    = P_WAKE_CYC[TMR_W-1:0];
	localparam logic [TMR_W-1:0] ATTACK_LIM  = ATTACK_CYC[TMR_W-1:0];
	localparam logic [TMR_W-1:0] HOLD_LIM    = P_HOLD_CYC[TMR_W-1:0];
	localparam logic [TMR_W-1:0] RELEASE_LIM = P_RELEASE_CYC[TMR_W-1:0];
	localparam logic [TMR_W-1:0] TMR_ONE     = 17'h00001;
	localparam logic [TMR_W-1:0] TMR_MAX     = 17'h1ffff;

	pcglc_state_e       state_ff;
	pcglc_state_e       nxt_state;
	logic               pin_d_ff;
	logic [TMR_W-1:0]   low_cnt_ff;
	logic [TMR_W-1:0]   high_cnt_ff;
	logic [TMR_W-1:0]   wake_cnt_ff;
	logic [4:0]         pulse_cnt_ff;
	logic               fall_edge;
	logic               apply_now;
	logic               go_shutdown;
	logic [4:0]         thd_off;
	logic [4:0]         peak_off;
	logic               agc_en_ff;
	logic               limit_en_ff;
	logic               gain_18_ff;
	logic [2:0]         thd_sel_ff;
	logic [2:0]         peak_sel_ff;
	logic [TMR_W-1:0]   since_dec_ff;
	logic [TMR_W-1:0]   since_inc_ff;
	logic [5:0]         atten_ff;
	logic               dec_req;
	logic               dec_now;
	logic               inc_now;
	logic [7:0]         ceiling_ff;
	logic               bridge_p_ff;
	logic               bridge_m_ff;
	logic               bridge_oe_ff;

	// ************************************************************
	// Line sampling and interval counters
	// ************************************************************
	// Counters saturate so a line parked high or low never wraps
	// back into a false shutdown or a second apply.
	assign fall_edge = pin_d_ff & ~i_pulse_config_pin;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pin_d_ff <= 1'h1;
		end else begin
			pin_d_ff <= i_pulse_config_pin;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			low_cnt_ff <= '0;
		end else if (i_pulse_config_pin) begin
			low_cnt_ff <= '0;
		end else if (low_cnt_ff != TMR_MAX) begin
			low_cnt_ff <= low_cnt_ff + TMR_ONE;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			high_cnt_ff <= '0;
		end else if (!i_pulse_config_pin) begin
			high_cnt_ff <= '0;
		end else if (high_cnt_ff != TMR_MAX) begin
			high_cnt_ff <= high_cnt_ff + TMR_ONE;
		end
	end

	// ************************************************************
	// Power state
	// ************************************************************
	assign go_shutdown = (low_cnt_ff >= SHDN_LIM); // RULE17

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_SHUTDOWN: begin
				if (i_pulse_config_pin) begin
					nxt_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (go_shutdown) begin
					nxt_state = ST_SHUTDOWN;
				end else if (wake_cnt_ff >= WAKE_LIM - TMR_ONE) begin
					nxt_state = ST_ACTIVE; // RULE18
				end
			end
			ST_ACTIVE: begin
				if (go_shutdown) begin
					nxt_state = ST_SHUTDOWN; // RULE17
				end
			end
			default: begin
				nxt_state = ST_SHUTDOWN;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			state_ff <= ST_WAKE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wake_cnt_ff <= '0;
		end else if (state_ff != ST_WAKE) begin
			wake_cnt_ff <= '0;
		end else if (wake_cnt_ff != TMR_MAX) begin
			wake_cnt_ff <= wake_cnt_ff + TMR_ONE;
		end
	end

	// ************************************************************
	// Pulse counting
	// ************************************************************
	// Edges during wake-up are dropped: the rising edge that leaves
	// shutdown must not be taken as part of a burst.
	assign apply_now = (state_ff == ST_ACTIVE) & (pulse_cnt_ff != 5'h00)
		& (high_cnt_ff >= VALID_LIM); // RULE16 RULE19 RULE20

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pulse_cnt_ff <= '0;
		end else if (state_ff != ST_ACTIVE || apply_now) begin
			pulse_cnt_ff <= '0;
		end else if (fall_edge && pulse_cnt_ff != CNT_SAT) begin
			pulse_cnt_ff <= pulse_cnt_ff + 5'h01; // RULE19
		end
	end

	// ************************************************************
	// Configuration decode
	// ************************************************************
	assign thd_off  = pulse_cnt_ff - CNT_THD_FIRST;
	assign peak_off = pulse_cnt_ff - CNT_PEAK_FIRST;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b || state_ff == ST_SHUTDOWN) begin
			agc_en_ff   <= RST_AGC_EN; // RULE1
			limit_en_ff <= RST_LIMIT_EN;
			gain_18_ff  <= RST_GAIN_18;
			thd_sel_ff  <= RST_THD_SEL;
			peak_sel_ff <= RST_PEAK_SEL;
		end else if (apply_now) begin
			case (pulse_cnt_ff)
				CNT_AGC_OFF: begin
					agc_en_ff <= 1'h0; // RULE2
				end
				CNT_AGC_ON: begin
					agc_en_ff <= 1'h1; // RULE2
				end
				CNT_RESET: begin
					agc_en_ff   <= RST_AGC_EN; // RULE3
					limit_en_ff <= RST_LIMIT_EN;
					gain_18_ff  <= RST_GAIN_18;
					thd_sel_ff  <= RST_THD_SEL;
					peak_sel_ff <= RST_PEAK_SEL;
				end
				CNT_GAIN_12: begin
					gain_18_ff <= 1'h0; // RULE4
				end
				CNT_GAIN_18: begin
					gain_18_ff <= 1'h1; // RULE4
				end
				CNT_CLIP_LIMIT: begin
					limit_en_ff <= 1'h1; // RULE6
				end
				CNT_CLIP_ONLY: begin
					limit_en_ff <= 1'h0; // RULE6
				end
				default: begin
					if (pulse_cnt_ff >= CNT_THD_FIRST && pulse_cnt_ff <= CNT_THD_LAST) begin
						thd_sel_ff <= thd_off[2:0]; // RULE5
					end else if (pulse_cnt_ff >= CNT_PEAK_FIRST
						&& pulse_cnt_ff <= CNT_PEAK_LAST) begin
						peak_sel_ff <= peak_off[2:0]; // RULE7
					end
					// Anything else, saturated counts included, is dropped
				end
			endcase
		end
	end

	// ************************************************************
	// Gain sequencer
	// ************************************************************
	// Attenuation is one step per event; the analog side maps the
	// step code to dB and compares against the selected targets.
	assign dec_req = (agc_en_ff & i_clip_near) // RULE9
		| (limit_en_ff & i_over_limit); // RULE8
	assign dec_now = dec_req & (atten_ff != ATTEN_MAX)
		& (since_dec_ff >= ATTACK_LIM); // RULE11
	assign inc_now = ~dec_req & (atten_ff != 6'h00)
		& (since_dec_ff >= HOLD_LIM) // RULE12
		& (since_inc_ff >= RELEASE_LIM); // RULE13

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			since_dec_ff <= TMR_MAX;
		end else if (dec_now) begin
			since_dec_ff <= TMR_ONE; // RULE11
		end else if (since_dec_ff != TMR_MAX) begin
			since_dec_ff <= since_dec_ff + TMR_ONE;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			since_inc_ff <= TMR_MAX;
		end else if (inc_now) begin
			since_inc_ff <= TMR_ONE; // RULE13
		end else if (since_inc_ff != TMR_MAX) begin
			since_inc_ff <= since_inc_ff + TMR_ONE;
		end
	end

	// With both functions off nothing may hold the gain down, so the
	// attenuation drops straight back instead of releasing slowly.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b || state_ff != ST_ACTIVE) begin
			atten_ff <= '0;
		end else if (!agc_en_ff && !limit_en_ff) begin
			atten_ff <= '0;
		end else if (dec_now) begin
			atten_ff <= atten_ff + 6'h01; // RULE9
		end else if (inc_now) begin
			atten_ff <= atten_ff - 6'h01;
		end
	end

	// ************************************************************
	// Supply tracking
	// ************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			ceiling_ff <= '0;
		end else begin
			ceiling_ff <= i_supply_level; // RULE10
		end
	end

	// ************************************************************
	// Bridge drive
	// ************************************************************
	// Release follows the overcurrent level, so recovery is automatic
	// with one cycle of latency and no latch to clear.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			bridge_oe_ff <= 1'h0;
		end else begin
			bridge_oe_ff <= (state_ff == ST_ACTIVE) & ~i_overcurrent; // RULE14
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			bridge_p_ff <= 1'h0;
			bridge_m_ff <= 1'h0;
		end else begin
			bridge_p_ff <= i_pwm_p;
			bridge_m_ff <= i_pwm_m;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_agc_en      = agc_en_ff;
	assign o_limit_en    = limit_en_ff;
	assign o_gain_18db   = gain_18_ff;
	assign o_thd_sel     = thd_sel_ff;
	assign o_peak_sel    = peak_sel_ff;
	assign o_gain_atten  = atten_ff;
	assign o_out_ceiling = ceiling_ff;
	assign o_bridge_p    = bridge_p_ff;
	assign o_bridge_m    = bridge_m_ff;
	assign o_bridge_p_oe = bridge_oe_ff;
	assign o_bridge_m_oe = bridge_oe_ff;
	assign o_shutdown    = (state_ff == ST_SHUTDOWN);
	assign o_awake       = (state_ff == ST_ACTIVE);

endmodule : pcglc_top

// ---- test/pcglc_sva.sv ----
/* Assertions on settings, gain stepping, bridge enable and wake timing.
 * Assumes it is bound into pcglc_top and is handed its shortened counts. */
`timescale 1ns/1ps
module pcglc_sva
	import pcglc_pkg::*;
#(
	parameter int P_VALID_CYC   = VALID_CYC,
	parameter int P_WAKE_CYC    = WAKE_CYC,
	parameter int P_HOLD_CYC    = HOLD_CYC,
	parameter int P_RELEASE_CYC = RELEASE_CYC
) (
	input wire logic       i_ref_clk,
	input wire logic       i_rst_b,
	input wire logic       i_pulse_config_pin,
	input wire logic       i_clip_near,
	input wire logic       i_over_limit,
	input wire logic [7:0] i_supply_level,
	input wire logic       i_overcurrent,
	input wire logic       i_pwm_p,
	input wire logic       i_pwm_m,
	input wire logic       o_bridge_p,
	input wire logic       o_bridge_m,
	input wire logic       o_agc_en,
	input wire logic       o_limit_en,
	input wire logic       o_gain_18db,
	input wire logic [2:0] o_thd_sel,
	input wire logic [2:0] o_peak_sel,
	input wire logic [5:0] o_gain_atten,
	input wire logic [7:0] o_out_ceiling,
	input wire logic       o_bridge_p_oe,
	input wire logic       o_shutdown,
	input wire logic       o_awake
);
	// ************
	// Helper logic
	// ************
	logic [5:0]  atten_q_ff;
	logic        req_q_ff;
	logic [16:0] dgap_ff, igap_ff, hcnt_ff, wcnt_ff;
	logic        dec, inc;
	logic [8:0]  cfg;
	assign cfg = {o_agc_en, o_limit_en, o_gain_18db, o_thd_sel, o_peak_sel};
	assign dec = o_gain_atten > atten_q_ff;
	// Forced clears (shutdown, both modes off) are not paced steps
	assign inc = (atten_q_ff == o_gain_atten + 6'h01) && o_awake && (o_agc_en || o_limit_en);
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			atten_q_ff <= 6'h00;
			req_q_ff   <= 1'b0;
			dgap_ff    <= '1;
			igap_ff    <= '1;
		end else begin
			atten_q_ff <= o_gain_atten;
			req_q_ff   <= o_awake && ((o_agc_en && i_clip_near) || (o_limit_en && i_over_limit));
			dgap_ff    <= dec ? 17'h0 : dgap_ff + {16'h0, ~&dgap_ff};
			igap_ff    <= inc ? 17'h0 : igap_ff + {16'h0, ~&igap_ff};
		end
	end
	always_ff @(posedge i_ref_clk) begin
		hcnt_ff <= (i_rst_b && i_pulse_config_pin) ? hcnt_ff + {16'h0, ~&hcnt_ff} : 17'h0;
		wcnt_ff <= (!i_rst_b || o_awake || o_shutdown) ? 17'h0 : wcnt_ff + 17'h1;
	end
	// ************
	// Properties
	// ************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	property p_ceil; $past(i_rst_b) |-> o_out_ceiling == $past(i_supply_level); endproperty
	a_ceil: assert property (p_ceil) else $error("ceiling does not follow supply");
	property p_oe; $past(i_rst_b) && !o_shutdown |-> o_bridge_p_oe == ($past(o_awake) && !$past(i_overcurrent)); endproperty
	a_oe: assert property (p_oe) else $error("bridge enable wrong");
	property p_dec; dec |-> req_q_ff; endproperty
	a_dec: assert property (p_dec) else $error("gain step down without cause");
	property p_att; dec |-> dgap_ff >= ATTACK_CYC - 1; endproperty
	a_att: assert property (p_att) else $error("step downs too close");
	property p_hold; inc |-> dgap_ff >= P_HOLD_CYC - 1; endproperty
	a_hold: assert property (p_hold) else $error("step up too soon after step down");
	property p_rel; inc |-> igap_ff >= P_RELEASE_CYC - 1; endproperty
	a_rel: assert property (p_rel) else $error("step ups too close");
	property p_drv; $past(i_rst_b) |-> {o_bridge_p, o_bridge_m} == $past({i_pwm_p, i_pwm_m}); endproperty
	a_drv: assert property (p_drv) else $error("bridge drive does not follow modulator");
	property p_sd; o_shutdown && $past(o_shutdown) |-> {cfg, o_gain_atten, o_bridge_p_oe} == 16'he380; endproperty
	a_sd: assert property (p_sd) else $error("shutdown state not at defaults");
	property p_wake; wcnt_ff <= P_WAKE_CYC + 3; endproperty
	a_wake: assert property (p_wake) else $error("wake takes too long");
	property p_cfg; $changed(cfg) && !o_shutdown |-> hcnt_ff >= P_VALID_CYC - 1; endproperty
	a_cfg: assert property (p_cfg) else $error("setting changed before idle interval");
endmodule : pcglc_sva

bind pcglc_top pcglc_sva #(.P_VALID_CYC(P_VALID_CYC), .P_WAKE_CYC(P_WAKE_CYC),
	.P_HOLD_CYC(P_HOLD_CYC), .P_RELEASE_CYC(P_RELEASE_CYC)) i_pcglc_sva (.i_ref_clk,
	.i_rst_b, .i_pulse_config_pin, .i_clip_near, .i_over_limit, .i_supply_level,
	.i_overcurrent, .i_pwm_p, .i_pwm_m, .o_bridge_p, .o_bridge_m,
	.o_agc_en, .o_limit_en, .o_gain_18db, .o_thd_sel, .o_peak_sel,
	.o_gain_atten, .o_out_ceiling, .o_bridge_p_oe, .o_shutdown, .o_awake);

// ---- test/pcglc_host_model.sv ----
/* Host side of the control line: pulse bursts and shutdown holds.
 * Assumes requests are sampled on the rising edge; pulse widths are scaled. */
`timescale 1ns/1ps
module pcglc_host_model #(
	parameter int P_HALF = 3,
	parameter int P_IDLE = 48,
	parameter int P_LOW  = 90
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_go,
	input  wire logic       i_sleep,
	input  wire logic [4:0] i_count,
	output logic            o_pin,
	output logic            o_done
);
	initial begin
		o_pin  = 1'b1;
		o_done = 1'b0;
	end
	// Requests are one-cycle pulses, long gone by the end of a
	// burst, so the done pulse is decided when the request is taken.
	always @(posedge i_ref_clk) begin
		if (i_go || i_sleep) begin
			if (i_sleep) begin
				#1 o_pin = 1'b0;
				repeat (P_LOW) @(posedge i_ref_clk);
				#1 o_pin = 1'b1;
			end
			if (i_go) begin
				repeat (i_count) begin
					#1 o_pin = 1'b0;
					repeat (P_HALF) @(posedge i_ref_clk);
					#1 o_pin = 1'b1;
					repeat (P_HALF) @(posedge i_ref_clk);
				end
				repeat (P_IDLE) @(posedge i_ref_clk);
			end
			@(posedge i_ref_clk);
			#1 o_done = 1'b1;
			@(posedge i_ref_clk);
			#1 o_done = 1'b0;
		end
	end
endmodule : pcglc_host_model

// ---- test/pcglc_top_tb.sv ----
/* Self-checking bench: host model drives the line, a watcher compares outputs.
 * Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
module pcglc_top_tb;
	import pcglc_pkg::*;
	localparam int VC = 40;
	localparam int WC = 20;
	logic        clk = 1'b0, rst_b = 1'b0, clip = 1'b0, over = 1'b0, oc = 1'b0;
	logic        pwm_p = 1'b0, pwm_m = 1'b0, go = 1'b0, sleep = 1'b0, look = 1'b0;
	logic [7:0]  supply = 8'h00;
	logic [4:0]  cnt = 5'h00;
	logic [31:0] rnd = 32'h47;
	wire         pin, done, agc, lim, g18, bp, bpoe, bm, bmoe, sd, awake;
	wire  [2:0]  thd, peak;
	wire  [5:0]  att;
	wire  [7:0]  ceil;
	logic [18:0] q[$];
	logic [8:0]  cfg = 9'h1c7;
	logic [5:0]  att_e = 6'h00;
	int          n_fail = 0, samples_checked = 0, cyc = 0;
	always #2.5 clk = ~clk;
	pcglc_top #(.P_VALID_CYC(VC), .P_SHUTDOWN_CYC(80), .P_WAKE_CYC(WC), .P_HOLD_CYC(30),
		.P_RELEASE_CYC(15)) i_pcglc_top (.i_ref_clk(clk), .i_rst_b(rst_b),
		.i_pulse_config_pin(pin), .i_clip_near(clip), .i_over_limit(over),
		.i_supply_level(supply), .i_overcurrent(oc), .i_pwm_p(pwm_p), .i_pwm_m(pwm_m),
		.o_agc_en(agc), .o_limit_en(lim), .o_gain_18db(g18), .o_thd_sel(thd),
		.o_peak_sel(peak), .o_gain_atten(att), .o_out_ceiling(ceil), .o_bridge_p(bp),
		.o_bridge_p_oe(bpoe), .o_bridge_m(bm), .o_bridge_m_oe(bmoe), .o_shutdown(sd),
		.o_awake(awake));
	pcglc_host_model #(.P_IDLE(VC + 8)) i_pcglc_host_model (.i_ref_clk(clk), .i_go(go),
		.i_sleep(sleep), .i_count(cnt), .o_pin(pin), .o_done(done));
	// ************
	// Helpers
	// ************
	function automatic logic [31:0] xs(logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [8:0] nxt(logic [8:0] c, int n);
		if (n == 0 || n > 23) c = c;
		else if (n == 1) c[8] = 1'b0;
		else if (n == 2) c[8] = 1'b1;
		else if (n == 3) c = 9'h1c7;
		else if (n <= 5) c[6] = (n == 5);
		else if (n <= 13) c[5:3] = 3'(n - 6);
		else if (n <= 15) c[7] = (n == 14);
		else c[2:0] = 3'(n - 16);
		return c;
	endfunction : nxt
	task automatic note(logic a, logic o);
		q.push_back({1'b0, a, o, o, cfg, att_e});
	endtask : note
	task automatic check(logic [18:0] s, logic [18:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task automatic peek(int w);
		repeat (w) @(posedge clk);
		#1 look = 1'b1;
		@(posedge clk);
		#1 look = 1'b0;
	endtask : peek
	task automatic burst(int n);
		cfg = nxt(cfg, n);
		note(1'b1, 1'b1);
		@(posedge clk);
		#1 cnt = n[4:0];
		go = 1'b1;
		@(posedge clk);
		#1 go = 1'b0;
		@(posedge clk iff done);
	endtask : burst
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	// ************
	// Processes
	// ************
	always @(posedge clk) begin
		#1 rnd = xs(rnd);
		supply = rnd[7:0];
		pwm_p = rnd[8];
		pwm_m = rnd[9];
	end
	always @(posedge clk) begin
		if (done === 1'b1 || look === 1'b1) begin
			check({sd, awake, bpoe, bmoe, agc, lim, g18, thd, peak, att}, q.pop_front());
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		#1 rst_b = 1'b1;
		note(1'b1, 1'b1);
		peek(WC + 5);
		$display("test wake defaults done");
		for (int n = 1; n <= 25; n++) burst(n);
		repeat (12) burst(int'(rnd[4:0]));
		$display("test pulse codes done");
		#1 oc = 1'b1;
		note(1'b1, 1'b0);
		peek(2);
		oc = 1'b0;
		note(1'b1, 1'b1);
		peek(2);
		$display("test overcurrent done");
		burst(3);
		burst(1);
		#1 over = 1'b1;
		att_e = 6'h01;
		note(1'b1, 1'b1);
		peek(4);
		over = 1'b0;
		clip = 1'b1;
		att_e = 6'h00;
		note(1'b1, 1'b1);
		peek(60);
		burst(2);
		att_e = 6'h01;
		note(1'b1, 1'b1);
		peek(1950);
		note(1'b1, 1'b1);
		peek(1850);
		att_e = 6'h02;
		note(1'b1, 1'b1);
		peek(100);
		clip = 1'b0;
		att_e = 6'h00;
		note(1'b1, 1'b1);
		peek(100);
		$display("test gain steps done");
		burst(4);
		cfg = 9'h1c7;
		q.push_back({4'b1000, cfg, 6'h00});
		@(posedge clk);
		#1 sleep = 1'b1;
		@(posedge clk);
		#1 sleep = 1'b0;
		peek(86);
		q.push_back({4'b0000, cfg, 6'h00});
		@(posedge clk iff done);
		note(1'b1, 1'b1);
		peek(WC + 5);
		$display("test shutdown done");
		close_out();
	end
endmodule : pcglc_top_tb
